// File: logic/uic_pkg.sv
// Constants shared by the UART interrupt, sleep and baud control block.
// Assumes a 32-bit APB register bus and one 200 MHz clock.
package uic_pkg;
  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_IER   = 8'h00;
  localparam logic [7:0] OFS_IIR   = 8'h04;
  localparam logic [7:0] OFS_LCR   = 8'h08;
  localparam logic [7:0] OFS_MCR   = 8'h0c;
  localparam logic [7:0] OFS_LSR   = 8'h10;
  localparam logic [7:0] OFS_EFR   = 8'h14;
  localparam logic [7:0] OFS_DLL   = 8'h18;
  localparam logic [7:0] OFS_DLH   = 8'h1c;
  localparam logic [7:0] OFS_IOEN  = 8'h20;
  localparam logic [7:0] OFS_PINST = 8'h24;
  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic [7:0] LCR_RST  = 8'h1d;
  localparam logic [7:0] ZERO_RST = 8'h00;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int IER_RX    = 0;
  localparam int IER_THR   = 1;
  localparam int IER_LINE  = 2;
  localparam int IER_MODEM = 3;
  localparam int IER_SLEEP = 4;
  localparam int IER_XOFF  = 5;
  localparam int IER_RTS   = 6;
  localparam int IER_CTS   = 7;
  localparam int EFR_ENH   = 4;
  localparam int LCR_BREAK = 6;
  localparam int MCR_PRESC = 7;
  // ----------------------------------------------------------------
  // Identification codes
  // ----------------------------------------------------------------
  localparam logic [5:0] IIR_NONE  = 6'h01;
  localparam logic [5:0] IIR_LINE  = 6'h06;
  localparam logic [5:0] IIR_TOUT  = 6'h0c;
  localparam logic [5:0] IIR_RHR   = 6'h04;
  localparam logic [5:0] IIR_THR   = 6'h02;
  localparam logic [5:0] IIR_MODEM = 6'h00;
  localparam logic [5:0] IIR_PINS  = 6'h30;
  localparam logic [5:0] IIR_XOFF  = 6'h10;
  localparam logic [5:0] IIR_RTSCTS = 6'h20;
  // ----------------------------------------------------------------
  // Counts of cycles and ticks
  // ----------------------------------------------------------------
  localparam int TICKS_PER_BIT_LOG2 = 4;
  localparam int TOUT_CHARS_LOG2    = 2;
  localparam int PRESC_DIV          = 4;
  // Sleep state machine.
  typedef enum logic [1:0] {
    SLP_AWAKE  = 2'b01,
    SLP_ASLEEP = 2'b10
  } uic_slp_t;
endpackage

// File: logic/uic_chg.sv
// Change and rising-edge detector for a group of synchronous pins.
// Assumes the inputs are already synchronous to the clock.
`timescale 1ns/1ps
module uic_chg #(
  parameter int W = 4
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Pins and events
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] chg_q,
  output logic      [W-1:0] rise_q
);
  logic [W-1:0] prev_q;
  logic         armed_q;

  // The history is cleared by reset, so the first compare is masked to avoid a false edge on idle-high pins.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_q  <= '0;
      armed_q <= 1'b0;
      chg_q   <= '0;
      rise_q  <= '0;
    end else begin
      prev_q  <= din;
      armed_q <= 1'b1;
      chg_q   <= (din ^ prev_q) & {W{armed_q}};
      rise_q  <= din & ~prev_q & {W{armed_q}};
    end
  end
endmodule // uic_chg

// File: logic/uic_baud.sv
// Prescaler and 16-bit divisor producing the sixteen-times baud tick.
// Assumes one clock; the tick is a one-cycle enable pulse.
`timescale 1ns/1ps
module uic_baud #(
  parameter int DIV_W = 16
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Control
  input  wire logic             run,
  input  wire logic             presc_sel,
  input  wire logic [DIV_W-1:0] divisor,
  // Tick
  output logic                  tick_q
);
  logic [1:0]       pre_q;
  logic [DIV_W-1:0] cnt_q;
  wire              pre_en = run & (~presc_sel | (pre_q == 2'(uic_pkg::PRESC_DIV - 1)));
  wire              wrap   = (cnt_q >= divisor - DIV_W'(1));
  wire              div_ok = (divisor != '0);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_q  <= '0;
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      if (run) begin
        pre_q <= pre_q + 2'd1;
      end
      tick_q <= pre_en & div_ok & wrap;
      if (pre_en & div_ok) begin
        cnt_q <= wrap ? '0 : cnt_q + DIV_W'(1);
      end
    end
  end
endmodule // uic_baud

// File: logic/uic_ctrl.sv
// UART interrupt priority, sleep control, time-out, break and baud control.
// Assumes the receiver, FIFOs and transmitter sit outside and report here.
//
// What this block does
// - code 000001 when nothing pending
// - line status errors give 000110, level 1
// - time-out 001100, receive data 000100, level 2
// - transmit holding gives 000010, level 3
// - modem pin change gives 000000, level 4
// - general pin change gives 110000, level 5
// - stop or special character gives 010000
// - RTS/CTS low-to-high gives 100000, level 7
// - FIFO error bit while any error held
// - error bits show head character, zero empty
// - resume clears stop; INTERRUPT_IDENTIFICATION_REG read clears special
// - low four enables select interrupt mode
// - sleep needs enhanced and sleep enables
// - sleep only when idle and empty
// - sleep stops clock; line changes wake
// - time-out after four idle character times
// - break when input low over character
// - break bit forces transmit output low
// - 16-bit divisor makes sixteen-times tick
// - prescaler divides by four when selected
// - zero divisor stops the baud tick
// - stop character interrupt needs enable five
//
// Decided for this implementation: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module uic_ctrl #(
  parameter int GPIO_W = 8
) (
  // Clock and reset
  input  wire logic              REF_CLK,
  input  wire logic              RST_N,
  // APB slave
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [7:0]        PADDR,
  input  wire logic [31:0]       PWDATA,
  output logic      [31:0]       PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR,
  // Receiver and FIFO status
  input  wire logic              RX_IN,
  input  wire logic              RX_EMPTY,
  input  wire logic              RX_TRIG,
  input  wire logic              RX_FIFO_RD,
  input  wire logic              RX_STOP_MID,
  input  wire logic              RX_ERR_ANY,
  input  wire logic [2:0]        RX_HEAD_ERR,
  input  wire logic              RX_OVERRUN,
  // Transmitter status
  input  wire logic              TX_TRIG,
  input  wire logic              TX_EMPTY,
  input  wire logic              TX_HOLD_EMPTY,
  input  wire logic              TX_FIFO_WR,
  // Pins and character events
  input  wire logic [3:0]        MODEM_IN,
  input  wire logic [GPIO_W-1:0] GPIO_IN,
  input  wire logic [1:0]        RTS_CTS_IN,
  input  wire logic              XOFF_DET,
  input  wire logic              XON_DET,
  input  wire logic              SPECIAL_DET,
  // Outputs to the UART and host
  output logic                   IRQ_N,
  output logic                   UART_CLK_EN,
  output logic                   BAUD16_TICK,
  output logic                   TX_FORCE_LOW,
  output logic                   BREAK_DET
);
  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_q;
  wire        rst_n = rst_sync_q[1];

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!rst_n);

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  logic [7:0]        ier_q, lcr_q, mcr_q, efr_q, dll_q, dlh_q;
  logic [GPIO_W-1:0] io_en_q;
  logic [31:0]       rdata_d;
  logic              mapped;
  wire               setup = PSEL & ~PENABLE & ~PREADY;
  wire               done  = PSEL & PENABLE & PREADY;
  wire               wr    = done & PWRITE & ~PSLVERR;
  wire               rd    = done & ~PWRITE;
  wire               rd_iir   = rd & (PADDR == uic_pkg::OFS_IIR);
  wire               rd_pinst = rd & (PADDR == uic_pkg::OFS_PINST);
  wire [15:0]        divisor  = {dlh_q, dll_q};
  logic [5:0]        interrupt_identification_reg;
  logic [7:0]        line_status_reg;
  logic [3:0]        modem_f_q;
  logic [GPIO_W-1:0] gpio_f_q;

  always_comb begin
    mapped  = 1'b1;
    rdata_d = '0;
    case (PADDR)
      uic_pkg::OFS_IER:   rdata_d[7:0] = ier_q;
      uic_pkg::OFS_IIR:   rdata_d[5:0] = interrupt_identification_reg;
      uic_pkg::OFS_LCR:   rdata_d[7:0] = lcr_q;
      uic_pkg::OFS_MCR:   rdata_d[7:0] = mcr_q;
      uic_pkg::OFS_LSR:   rdata_d[7:0] = line_status_reg;
      uic_pkg::OFS_EFR:   rdata_d[7:0] = efr_q;
      uic_pkg::OFS_DLL:   rdata_d[7:0] = dll_q;
      uic_pkg::OFS_DLH:   rdata_d[7:0] = dlh_q;
      uic_pkg::OFS_IOEN:  rdata_d[GPIO_W-1:0] = io_en_q;
      uic_pkg::OFS_PINST: rdata_d[GPIO_W+5:0] = {GPIO_IN, RTS_CTS_IN, MODEM_IN};
      default:            mapped = 1'b0;
    endcase
  end

  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= '0;
    end else begin
      PREADY  <= setup;
      PSLVERR <= setup & ~mapped;
      if (setup) begin
        PRDATA <= rdata_d;
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      ier_q   <= uic_pkg::ZERO_RST;
      lcr_q   <= uic_pkg::LCR_RST;
      mcr_q   <= uic_pkg::ZERO_RST;
      efr_q   <= uic_pkg::ZERO_RST;
      dll_q   <= uic_pkg::ZERO_RST;
      dlh_q   <= uic_pkg::ZERO_RST;
      io_en_q <= '0;
    end else if (wr) begin
      case (PADDR)
        uic_pkg::OFS_IER:  ier_q <= PWDATA[7:0];
        uic_pkg::OFS_LCR:  lcr_q <= PWDATA[7:0];
        uic_pkg::OFS_MCR:  mcr_q <= {efr_q[uic_pkg::EFR_ENH] ? PWDATA[7] : mcr_q[7], PWDATA[6:0]};
        uic_pkg::OFS_EFR:  efr_q <= PWDATA[7:0];
        uic_pkg::OFS_DLL:  dll_q <= PWDATA[7:0];
        uic_pkg::OFS_DLH:  dlh_q <= PWDATA[7:0];
        uic_pkg::OFS_IOEN: io_en_q <= PWDATA[GPIO_W-1:0];
        default:           ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Baud generator and character timing
  // ----------------------------------------------------------------
  uic_pkg::uic_slp_t slp_q;
  uic_pkg::uic_slp_t slp_d;
  wire               awake = (slp_d == uic_pkg::SLP_AWAKE);
  logic              tick;

  uic_baud #(
    .DIV_W     (16)
  ) u_baud (
    .clk       (REF_CLK),
    .rst_n     (rst_n),
    .run       (awake),
    .presc_sel (mcr_q[uic_pkg::MCR_PRESC]),
    .divisor   (divisor),
    .tick_q    (tick)
  );
  assign BAUD16_TICK = tick;

  // Bits in a character: start, data, parity and stop.
  wire [3:0] char_bits = 4'd1 + 4'd5 + {2'b00, lcr_q[1:0]} + {3'b000, lcr_q[3]}
                       + (lcr_q[2] ? 4'd2 : 4'd1);
  wire [7:0] char_ticks = {char_bits, 4'h0};
  wire [9:0] tout_ticks = {char_bits, 6'h00};

  // ----------------------------------------------------------------
  // Time-out and break
  // ----------------------------------------------------------------
  logic [9:0] tout_cnt_q;
  logic       tout_q;
  logic [7:0] brk_cnt_q;
  wire        tout_rst = RX_STOP_MID | RX_FIFO_RD | RX_EMPTY;

  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      tout_cnt_q <= '0;
      tout_q     <= 1'b0;
      brk_cnt_q  <= '0;
      BREAK_DET  <= 1'b0;
    end else begin
      if (tout_rst) begin
        tout_cnt_q <= '0;
        tout_q     <= 1'b0;
      end else if (tick & (tout_cnt_q < tout_ticks)) begin
        tout_cnt_q <= tout_cnt_q + 10'd1;
      end else if (tout_cnt_q >= tout_ticks) begin
        tout_q <= ~RX_TRIG;
      end
      if (RX_IN) begin
        brk_cnt_q <= '0;
      end else if (tick & (brk_cnt_q <= char_ticks)) begin
        brk_cnt_q <= brk_cnt_q + 8'd1;
      end
      BREAK_DET <= ~RX_IN & (brk_cnt_q > char_ticks);
    end
  end

  // ----------------------------------------------------------------
  // Pin change detection
  // ----------------------------------------------------------------
  logic [3:0]        modem_chg;
  logic [GPIO_W-1:0] gpio_chg;
  logic [1:0]        rc_rise;
  logic              rx_chg;

  uic_chg #(.W(4)) u_modem (
    .clk    (REF_CLK),
    .rst_n  (rst_n),
    .din    (MODEM_IN),
    .chg_q  (modem_chg),
    .rise_q ()
  );
  uic_chg #(.W(GPIO_W)) u_gpio (
    .clk    (REF_CLK),
    .rst_n  (rst_n),
    .din    (GPIO_IN),
    .chg_q  (gpio_chg),
    .rise_q ()
  );
  uic_chg #(.W(2)) u_rtscts (
    .clk    (REF_CLK),
    .rst_n  (rst_n),
    .din    (RTS_CTS_IN),
    .chg_q  (),
    .rise_q (rc_rise)
  );
  uic_chg #(.W(1)) u_rx (
    .clk    (REF_CLK),
    .rst_n  (rst_n),
    .din    (RX_IN),
    .chg_q  (rx_chg),
    .rise_q ()
  );

  // ----------------------------------------------------------------
  // Sticky interrupt flags
  // ----------------------------------------------------------------
  logic [1:0] rc_f_q;
  logic       xoff_f_q, spec_f_q;

  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      modem_f_q <= '0;
      gpio_f_q  <= '0;
      rc_f_q    <= '0;
      xoff_f_q  <= 1'b0;
      spec_f_q  <= 1'b0;
    end else begin
      modem_f_q <= modem_chg | (modem_f_q & {4{~rd_pinst}});
      gpio_f_q  <= gpio_chg | (gpio_f_q & {GPIO_W{~rd_pinst}});
      rc_f_q    <= rc_rise | (rc_f_q & {2{~rd_iir}});
      xoff_f_q  <= XOFF_DET | (xoff_f_q & ~XON_DET);
      spec_f_q  <= SPECIAL_DET | (spec_f_q & ~rd_iir);
    end
  end

  // ----------------------------------------------------------------
  // Line status and priority
  // ----------------------------------------------------------------
  // any error in FIFO
  assign line_status_reg = {RX_ERR_ANY, TX_EMPTY, TX_HOLD_EMPTY,
                RX_HEAD_ERR & {3{~RX_EMPTY}}, RX_OVERRUN, ~RX_EMPTY};

  wire p_line  = ier_q[uic_pkg::IER_LINE] & (RX_ERR_ANY | RX_OVERRUN);
  wire p_tout  = ier_q[uic_pkg::IER_RX] & tout_q;
  wire p_rhr   = ier_q[uic_pkg::IER_RX] & RX_TRIG;
  wire p_thr   = ier_q[uic_pkg::IER_THR] & TX_TRIG;
  wire p_modem = ier_q[uic_pkg::IER_MODEM] & (|modem_f_q);
  wire p_pins  = |(gpio_f_q & io_en_q);
  wire p_xoff  = ier_q[uic_pkg::IER_XOFF] & (xoff_f_q | spec_f_q);
  wire p_rc    = (ier_q[uic_pkg::IER_RTS] & rc_f_q[1]) | (ier_q[uic_pkg::IER_CTS] & rc_f_q[0]);
  wire pend_other = p_line | p_tout | p_rhr | p_modem | p_pins | p_xoff | p_rc;

  assign interrupt_identification_reg = p_line  ? uic_pkg::IIR_LINE  :
               p_tout  ? uic_pkg::IIR_TOUT  :
               p_rhr   ? uic_pkg::IIR_RHR   :
               p_thr   ? uic_pkg::IIR_THR   :
               p_modem ? uic_pkg::IIR_MODEM :
               p_pins  ? uic_pkg::IIR_PINS  :
               p_xoff  ? uic_pkg::IIR_XOFF  :
               p_rc    ? uic_pkg::IIR_RTSCTS : uic_pkg::IIR_NONE;

  // ----------------------------------------------------------------
  // Sleep control
  // ----------------------------------------------------------------
  // both enables needed
  wire slp_en  = efr_q[uic_pkg::EFR_ENH] & ier_q[uic_pkg::IER_SLEEP];
  wire slp_ok  = slp_en & RX_IN & (brk_cnt_q == '0) & TX_EMPTY & RX_EMPTY & ~pend_other;
  wire wake    = rx_chg | (|modem_chg) | TX_FIFO_WR | ~slp_en;

  always_comb begin
    case (slp_q)
      uic_pkg::SLP_AWAKE:  slp_d = slp_ok ? uic_pkg::SLP_ASLEEP : uic_pkg::SLP_AWAKE;
      uic_pkg::SLP_ASLEEP: slp_d = wake ? uic_pkg::SLP_AWAKE : uic_pkg::SLP_ASLEEP;
      default:             slp_d = uic_pkg::SLP_AWAKE;
    endcase
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      slp_q        <= uic_pkg::SLP_AWAKE;
      UART_CLK_EN  <= 1'b1;
      IRQ_N        <= 1'b1;
      TX_FORCE_LOW <= 1'b0;
    end else begin
      slp_q        <= slp_d;
      UART_CLK_EN  <= (slp_d == uic_pkg::SLP_AWAKE);
      IRQ_N        <= (interrupt_identification_reg == uic_pkg::IIR_NONE);
      TX_FORCE_LOW <= lcr_q[uic_pkg::LCR_BREAK];
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  idle_code_a: assert property (~(pend_other | p_thr) |-> interrupt_identification_reg == 6'h01)
    else $error("idle code wrong");
  line_first_a: assert property (p_line |-> interrupt_identification_reg == 6'h06)
    else $error("line status not first");
  tout_prio_a: assert property (p_tout & ~p_line |-> interrupt_identification_reg == 6'h0c)
    else $error("time-out code wrong");
  irq_pin_a: assert property ((pend_other | p_thr) |=> !IRQ_N)
    else $error("interrupt pin not low");
  brk_tx_a: assert property ($rose(lcr_q[6]) |=> TX_FORCE_LOW [*2])
    else $error("break not forced");
  sleep_cond_a: assert property ($rose(slp_q == uic_pkg::SLP_ASLEEP) |-> $past(RX_EMPTY & TX_EMPTY & slp_en))
    else $error("sleep entered early");
  sleep_clk_a: assert property (slp_q == uic_pkg::SLP_ASLEEP |-> !UART_CLK_EN && !tick)
    else $error("clock runs in sleep");
  zero_div_a: assert property (divisor == 16'h0000 [*2] |-> !tick)
    else $error("tick with zero divisor");
  lsr_empty_a: assert property (RX_EMPTY |-> line_status_reg[4:2] == 3'b000)
    else $error("error bits set while empty");
  spec_clr_a: assert property (rd_iir & ~SPECIAL_DET |=> !spec_f_q)
    else $error("special flag not cleared");
endmodule // uic_ctrl

// File: testbench/uic_line_model.sv
// Serial receive line model for the UART control block.
// Assumes the bench raises brk_req for at least one clock with brk_len set.
`timescale 1ns/1ps
module uic_line_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Request
  input  wire logic        brk_req,
  input  wire logic [15:0] brk_len,
  // Line
  output logic             rx_line,
  output logic             busy
);
  logic [15:0] cnt_q;
  // ----------------------------------------------------------------
  // Line hold
  // ----------------------------------------------------------------
  // line held low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 16'h0000;
    end else if (brk_req) begin
      cnt_q <= brk_len;
    end else if (cnt_q != 16'h0000) begin
      cnt_q <= cnt_q - 16'h0001;
    end
  end
  // The line idles high whenever no low spell is requested.
  assign busy    = (cnt_q != 16'h0000);
  assign rx_line = ~busy;
endmodule // uic_line_model

// File: testbench/uart_irq_sleep_baud_control_tb.sv
// Self-checking bench for the UART interrupt, sleep and baud control block.
// Assumes a zero-wait APB slave and a receive line model on RX_IN.
`timescale 1ns/1ps
`define CHK(nm, e, s) begin cmp_count++; if ((e) !== (s)) begin fail_count++; \
  $display("[FAIL] %s exp %h got %h", nm, e, s); end end
module uart_irq_sleep_baud_control_tb;
  logic        REF_CLK, RST_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  logic [7:0]  PADDR, GPIO_IN;
  logic [31:0] PWDATA, PRDATA, rd, h;
  logic        RX_IN, RX_EMPTY, RX_TRIG, RX_FIFO_RD, RX_STOP_MID, RX_ERR_ANY, RX_OVERRUN;
  logic [2:0]  RX_HEAD_ERR;
  logic        TX_TRIG, TX_EMPTY, TX_HOLD_EMPTY, TX_FIFO_WR, XOFF_DET, XON_DET, SPECIAL_DET;
  logic [3:0]  MODEM_IN;
  logic [1:0]  RTS_CTS_IN;
  logic        IRQ_N, UART_CLK_EN, BAUD16_TICK, TX_FORCE_LOW, BREAK_DET, brk_req, busy, err;
  logic [15:0] brk_len;
  int          fail_count, cmp_count, d;
  wire  [3:0]  mon = {busy, BAUD16_TICK, UART_CLK_EN, IRQ_N};

  uic_ctrl #(.GPIO_W(8)) uic_ctrl_inst (.REF_CLK, .RST_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
    .PRDATA, .PREADY, .PSLVERR, .RX_IN, .RX_EMPTY, .RX_TRIG, .RX_FIFO_RD, .RX_STOP_MID, .RX_ERR_ANY,
    .RX_HEAD_ERR, .RX_OVERRUN, .TX_TRIG, .TX_EMPTY, .TX_HOLD_EMPTY, .TX_FIFO_WR, .MODEM_IN, .GPIO_IN,
    .RTS_CTS_IN, .XOFF_DET, .XON_DET, .SPECIAL_DET, .IRQ_N, .UART_CLK_EN, .BAUD16_TICK, .TX_FORCE_LOW,
    .BREAK_DET);
  uic_line_model uic_line_model_inst (.clk(REF_CLK), .rst_n(RST_N), .brk_req(brk_req),
    .brk_len(brk_len), .rx_line(RX_IN), .busy(busy));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic wait_on(input int k, input logic v);
    int n;
    n = 0;
    while (mon[k] !== v && n < 2000) begin
      @(posedge REF_CLK);
      n++;
    end
    if (n >= 2000) begin
      fail_count++;
      $display("[FAIL] wait %0d exp %b got timeout", k, v);
      tally_and_finish;
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge REF_CLK);
    PSEL    <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE  <= w;
    PADDR   <= a;
    PWDATA  <= wd;
    @(posedge REF_CLK);
    PENABLE <= 1'b1;
    n = 0;
    do begin
      @(posedge REF_CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 16);
    if (n >= 16) begin
      fail_count++;
      $display("[FAIL] apb exp ready got timeout");
      tally_and_finish;
    end
    rd = PRDATA;
    err = PSLVERR;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  task automatic interrupt_identification_reg(input logic [5:0] e);
    apb(1'b0, uic_pkg::OFS_IIR, 32'h0);
    `CHK("iir", e, rd[5:0])
  endtask

  // Pulse index: 0 stop centre, 1 fifo read, 2 tx write, 3 stop char, 4 resume char, 5 special.
  task automatic pulse(input int k);
    @(posedge REF_CLK);
    {SPECIAL_DET, XON_DET, XOFF_DET, TX_FIFO_WR, RX_FIFO_RD, RX_STOP_MID} <= 6'h01 << k;
    @(posedge REF_CLK);
    {SPECIAL_DET, XON_DET, XOFF_DET, TX_FIFO_WR, RX_FIFO_RD, RX_STOP_MID} <= 6'h00;
  endtask

  task automatic meas(input int e);
    int n;
    wait_on(2, 1'b1);
    repeat (2) begin
      n = 0;
      do begin
        @(posedge REF_CLK);
        n++;
      end while (BAUD16_TICK !== 1'b1 && n < 2000);
    end
    `CHK("baud period", e, n)
  endtask

  task automatic brk(input int len, input int at, input logic e);
    @(posedge REF_CLK);
    {brk_len, brk_req} <= {16'(len), 1'b1};
    @(posedge REF_CLK);
    brk_req <= 1'b0;
    repeat (at) @(posedge REF_CLK);
    `CHK("break", e, BREAK_DET)
    wait_on(3, 1'b0);
  endtask

  function automatic logic [7:0] lsr_exp(input logic [7:0] v);
    return {v[4], v[6], v[7], v[2:0] & {3{~v[3]}}, v[5], ~v[3]};
  endfunction

  initial begin
    REF_CLK = 1'b0;
    forever #2.5 REF_CLK = ~REF_CLK;
  end

  initial begin
    repeat (100000) @(posedge REF_CLK);
    fail_count++;
    tally_and_finish;
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {RST_N, PSEL, PENABLE, PWRITE, PADDR, PWDATA, brk_req, brk_len} = '0;
    {RX_TRIG, RX_FIFO_RD, RX_STOP_MID, RX_ERR_ANY, RX_OVERRUN, RX_HEAD_ERR} = '0;
    {TX_TRIG, TX_FIFO_WR, XOFF_DET, XON_DET, SPECIAL_DET, MODEM_IN, GPIO_IN, RTS_CTS_IN} = '0;
    {RX_EMPTY, TX_EMPTY, TX_HOLD_EMPTY} = 3'b111;
    h = $urandom(32'hb7548280);
    repeat (4) @(posedge REF_CLK);
    RST_N <= 1'b1;
    repeat (4) @(posedge REF_CLK);
    interrupt_identification_reg(uic_pkg::IIR_NONE);
    apb(1'b0, uic_pkg::OFS_LCR, 32'h0);
    `CHK("lcr reset", uic_pkg::LCR_RST, rd[7:0])
    apb(1'b0, 8'h40, 32'h0);
    `CHK("unmapped", 1'b1, err)
    apb(1'b1, uic_pkg::OFS_IER, 32'hef);
    apb(1'b1, uic_pkg::OFS_IOEN, 32'hff);
    {RX_ERR_ANY, RX_TRIG, TX_TRIG} <= 3'b111;
    wait_on(0, 1'b0);
    interrupt_identification_reg(uic_pkg::IIR_LINE);
    RX_ERR_ANY <= 1'b0;
    interrupt_identification_reg(uic_pkg::IIR_RHR);
    RX_TRIG <= 1'b0;
    interrupt_identification_reg(uic_pkg::IIR_THR);
    TX_TRIG <= 1'b0;
    h = $urandom;
    MODEM_IN <= h[3:0] | 4'h1;
    GPIO_IN <= h[11:4] | 8'h01;
    repeat (2) @(posedge REF_CLK);
    interrupt_identification_reg(uic_pkg::IIR_MODEM);
    apb(1'b0, uic_pkg::OFS_PINST, 32'h0);
    GPIO_IN <= ~GPIO_IN;
    repeat (2) @(posedge REF_CLK);
    interrupt_identification_reg(uic_pkg::IIR_PINS);
    apb(1'b0, uic_pkg::OFS_PINST, 32'h0);
    apb(1'b1, uic_pkg::OFS_IER, 32'hcf);
    pulse(3);
    repeat (4) @(posedge REF_CLK);
    `CHK("stop char masked", 1'b1, IRQ_N)
    apb(1'b1, uic_pkg::OFS_IER, 32'hef);
    interrupt_identification_reg(uic_pkg::IIR_XOFF);
    pulse(4);
    interrupt_identification_reg(uic_pkg::IIR_NONE);
    pulse(5);
    interrupt_identification_reg(uic_pkg::IIR_XOFF);
    interrupt_identification_reg(uic_pkg::IIR_NONE);
    RTS_CTS_IN <= 2'b10;
    repeat (2) @(posedge REF_CLK);
    interrupt_identification_reg(uic_pkg::IIR_RTSCTS);
    interrupt_identification_reg(uic_pkg::IIR_NONE);
    apb(1'b1, uic_pkg::OFS_IER, 32'h0);
    RX_TRIG <= 1'b1;
    repeat (8) begin
      h = $urandom;
      {TX_HOLD_EMPTY, TX_EMPTY, RX_OVERRUN, RX_ERR_ANY, RX_EMPTY, RX_HEAD_ERR} <= h[7:0];
      apb(1'b0, uic_pkg::OFS_LSR, 32'h0);
      `CHK("lsr", lsr_exp(h[7:0]), rd[7:0])
      `CHK("polled irq", 1'b1, IRQ_N)
    end
    RX_TRIG <= 1'b0;
    {TX_HOLD_EMPTY, TX_EMPTY, RX_OVERRUN, RX_ERR_ANY, RX_EMPTY, RX_HEAD_ERR} <= 8'hc8;
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, uic_pkg::OFS_LCR, i == 0 ? 32'h5d : 32'h1d);
      apb(1'b0, uic_pkg::OFS_LCR, 32'h0);
      `CHK("force low", ~i[0], TX_FORCE_LOW)
    end
    d = 2 + $urandom % 8;
    apb(1'b1, uic_pkg::OFS_DLL, 32'(d));
    meas(d);
    apb(1'b1, uic_pkg::OFS_MCR, 32'h80);
    apb(1'b0, uic_pkg::OFS_MCR, 32'h0);
    `CHK("prescaler locked", 1'b0, rd[7])
    apb(1'b1, uic_pkg::OFS_EFR, 32'h10);
    apb(1'b1, uic_pkg::OFS_MCR, 32'h80);
    meas(4 * d);
    apb(1'b1, uic_pkg::OFS_MCR, 32'h0);
    apb(1'b1, uic_pkg::OFS_DLL, 32'h0);
    apb(1'b1, uic_pkg::OFS_DLH, 32'h1);
    meas(256);
    apb(1'b1, uic_pkg::OFS_DLH, 32'h0);
    repeat (2) @(posedge REF_CLK);
    d = 0;
    repeat (600) begin
      @(posedge REF_CLK);
      d += int'(BAUD16_TICK === 1'b1);
    end
    `CHK("ticks zero divisor", 0, d)
    apb(1'b1, uic_pkg::OFS_DLL, 32'h1);
    // A character here is 10 bits of 16 ticks, one tick per clock.
    brk(150, 148, 1'b0);
    brk(300, 200, 1'b1);
    apb(1'b1, uic_pkg::OFS_IER, 32'h1);
    RX_EMPTY <= 1'b0;
    pulse(0);
    repeat (500) @(posedge REF_CLK);
    `CHK("early timeout", 1'b1, IRQ_N)
    pulse(1);
    repeat (500) @(posedge REF_CLK);
    `CHK("timeout restart", 1'b1, IRQ_N)
    wait_on(0, 1'b0);
    interrupt_identification_reg(uic_pkg::IIR_TOUT);
    RX_EMPTY <= 1'b1;
    apb(1'b1, uic_pkg::OFS_EFR, 32'h0);
    apb(1'b1, uic_pkg::OFS_IER, 32'h10);
    repeat (20) @(posedge REF_CLK);
    `CHK("no sleep", 1'b1, UART_CLK_EN)
    apb(1'b1, uic_pkg::OFS_EFR, 32'h10);
    for (int i = 0; i < 3; i++) begin
      wait_on(1, 1'b0);
      `CHK("asleep", 1'b0, UART_CLK_EN)
      if (i == 0) MODEM_IN <= ~MODEM_IN;
      else if (i == 1) {brk_len, brk_req} <= {16'd20, 1'b1};
      else {RX_EMPTY, TX_FIFO_WR} <= 2'b01;
      wait_on(1, 1'b1);
      brk_req <= 1'b0;
      TX_FIFO_WR <= 1'b0;
      `CHK("wake", 1'b1, UART_CLK_EN)
    end
    repeat (20) @(posedge REF_CLK);
    `CHK("stay awake", 1'b1, UART_CLK_EN)
    apb(1'b1, uic_pkg::OFS_IER, 32'h0);
    apb(1'b1, uic_pkg::OFS_DLL, 32'h3);
    meas(3);
    tally_and_finish;
  end
endmodule // uart_irq_sleep_baud_control_tb
